// ### rtl/reset_seq_defines.svh
// Offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

`define CLK_PERIOD_NS        10
`define STARTUP_CYCLES       1024
`define STARTUP_WIDTH        11
`define POWERUP_WIDTH        16
`define POWERUP_DELAY_TICKS  72
`define BO_FILTER_TIME_NS    100
`define BO_FILTER_CYCLES     ((`BO_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIN_FILTER_CYCLES    2

`define ADDR_POWER_STATUS    4'h0
`define ADDR_RESET_STATUS    4'h1
`define ADDR_CONFIG          4'h2

`define PS_BROWNOUT_BIT      0
`define PS_POWERON_BIT       1
`define PS_OSC_FAST_BIT      3
`define RS_TIMEOUT_BIT       4
`define RS_POWERDOWN_BIT     3
`define RS_HOLD_BIT          1
`define RS_RESET_BIT         0
`define CFG_POWERUP_EN_N_BIT 0
`define CFG_BO_EN_BIT        1
`define CFG_TRIP_LSB         2
`define CFG_MODE_LSB         4

`define CONFIG_RESET         8'h00
`define PC_RESET_VECTOR      13'h0000
`define PC_IRQ_VECTOR        13'h0004

`endif

// ### rtl/reset_seq_pkg.sv
// Types shared by the reset sequencer files
package reset_seq_pkg;
   typedef enum logic [2:0] {
      lowpower_crystal_mode,
      crystal_osc_mode,
      fast_crystal_mode,
      external_clock_mode,
      resistor_set_osc_mode,
      internal_rc_mode
   } osc_mode_t;

   typedef enum logic [2:0] {
      st_hold,
      st_powerup,
      st_osc_startup,
      st_run,
      st_wdt_rst,
      st_wake_startup
   } seq_state_t;
endpackage

// ### rtl/sync_filter.sv
// Two-flop synchroniser followed by a persistence filter on the high level
`timescale 1ns/1ns
`default_nettype none
module sync_filter #(
   parameter int unsigned HOLD_CYCLES = 1,
   parameter logic        RESET_LEVEL = 1'b0
)(
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   input  wire logic level_in,
   output logic      level_out
);
   localparam logic [15:0] LAST = 16'(HOLD_CYCLES - 1);
   logic        meta_ff;
   logic        sync_ff;
   logic [15:0] run_ff;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         meta_ff <= RESET_LEVEL;
         sync_ff <= RESET_LEVEL;
      end else begin
         meta_ff <= level_in;
         sync_ff <= meta_ff;
      end
   end

   // High must persist; low passes at once so a fall to low is never delayed
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         run_ff    <= 16'h0000;
         level_out <= RESET_LEVEL;
      end else if (!sync_ff) begin
         run_ff    <= 16'h0000;
         level_out <= 1'b0;
      end else if (run_ff == LAST) begin
         level_out <= 1'b1;
      end else begin
         run_ff <= run_ff + 16'h0001;
      end
   end
endmodule // sync_filter
`default_nettype wire

// ### rtl/delay_counter.sv
// Reloadable down-counter that flags the step that completes its length
`timescale 1ns/1ns
`default_nettype none
module delay_counter #(
   parameter int unsigned WIDTH  = 11,
   parameter int unsigned LENGTH = 1024
)(
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   input  wire logic load_in,
   input  wire logic step_in,
   output logic      done_out
);
   localparam logic [WIDTH-1:0] LAST_COUNT = WIDTH'(LENGTH - 1);
   logic [WIDTH-1:0] cnt_ff;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in || load_in) begin
         cnt_ff <= LAST_COUNT;
      end else if (step_in && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   assign done_out = step_in && (cnt_ff == '0);
endmodule // delay_counter
`default_nettype wire

// ### rtl/reset_timeout_sequencer.sv
// Reset, brown-out and start-up time-out sequencer for an 8-bit core
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "reset_seq_defines.svh"

module reset_timeout_sequencer #(
   parameter int unsigned POWERUP_DELAY_TICKS    = `POWERUP_DELAY_TICKS,
   parameter int unsigned BROWNOUT_FILTER_CYCLES = `BO_FILTER_CYCLES
)(
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        por_pulse_in,
   input  wire logic        brownout_below_in,
   input  wire logic        external_reset_pin_n_in,
   input  wire logic        rc_timebase_in,
   input  wire logic        wdt_timeout_in,
   input  wire logic        irq_wake_in,
   input  wire logic        sleeping_in,
   input  wire logic        global_irq_enable_in,
   input  wire logic [3:0]  reg_addr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             reset_out,
   output logic             core_hold_out,
   output logic             pc_load_out,
   output logic      [12:0] pc_value_out,
   output logic             pc_advance_out,
   output logic             periph_init_out,
   output logic             period_init_out,
   output logic             timeout_flag_n_out,
   output logic             powerdown_flag_n_out,
   output logic      [1:0]  brownout_trip_voltage_out
);
   import reset_seq_pkg::*;

   function automatic logic is_crystal(input osc_mode_t m);
      is_crystal = (m == lowpower_crystal_mode) || (m == crystal_osc_mode) ||
                   (m == fast_crystal_mode);
   endfunction

   logic       por_s;
   logic       bo_low_f;
   logic       pin_n_s;
   logic       rc_s;
   logic       rc_prev_ff;
   logic       por_prev_ff;
   logic       bo_prev_ff;
   logic       pin_prev_ff;
   logic       bo_cause_ff;
   logic [7:0] cfg_ff;
   logic       bo_flag_n_ff;
   logic       po_flag_n_ff;
   logic       osc_fast_ff;
   seq_state_t state_ff;
   seq_state_t nxt_state;
   osc_mode_t  mode;
   logic       crystal;
   logic       bo_en;
   logic       bo_trip;
   logic       powerup_on_por;
   logic       rc_tick;
   logic       live;
   logic       por_evt;
   logic       bo_evt;
   logic       pin_evt;
   logic       wdt_rst_evt;
   logic       wdt_wake_evt;
   logic       irq_wake_evt;
   logic       any_rst_evt;
   logic       powerup_done;
   logic       osc_startup_done;
   logic [7:0] ps_view;
   logic [7:0] rs_view;

   // ****************************************
   // Input synchronisers
   // ****************************************
   sync_filter #(.HOLD_CYCLES(1), .RESET_LEVEL(1'b1)) u_por_sync (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (por_pulse_in),
      .level_out  (por_s)
   );

   // Short dips never reach the sequencer
   sync_filter #(.HOLD_CYCLES(BROWNOUT_FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_bo_filt (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (brownout_below_in),
      .level_out  (bo_low_f)
   );

   sync_filter #(.HOLD_CYCLES(`PIN_FILTER_CYCLES), .RESET_LEVEL(1'b0)) u_pin_sync (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (external_reset_pin_n_in),
      .level_out  (pin_n_s)
   );

   sync_filter #(.HOLD_CYCLES(1), .RESET_LEVEL(1'b0)) u_rc_sync (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (rc_timebase_in),
      .level_out  (rc_s)
   );

   // ****************************************
   // Configuration decode and events
   // ****************************************
   always_comb begin
      mode        = osc_mode_t'(cfg_ff[`CFG_MODE_LSB +: 3]);
      crystal     = is_crystal(mode);
      bo_en       = cfg_ff[`CFG_BO_EN_BIT];
      bo_trip     = bo_low_f && bo_en;
      powerup_on_por = !cfg_ff[`CFG_POWERUP_EN_N_BIT] || bo_en;
      rc_tick     = rc_s && !rc_prev_ff;
      live        = (state_ff == st_run) && pin_n_s && !por_s && !bo_trip;
      por_evt     = por_s && !por_prev_ff;
      bo_evt      = bo_trip && !bo_prev_ff && !por_s;
      pin_evt     = !pin_n_s && pin_prev_ff && !por_s && !bo_trip;
      wdt_rst_evt = live && wdt_timeout_in && !sleeping_in;
      wdt_wake_evt = live && wdt_timeout_in && sleeping_in;
      irq_wake_evt = live && irq_wake_in && sleeping_in && !wdt_timeout_in;
      any_rst_evt = por_evt || bo_evt || pin_evt || wdt_rst_evt;
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rc_prev_ff  <= 1'b0;
         // Matches the preset of the power-on synchroniser: no false edge after reset
         por_prev_ff <= 1'b1;
         bo_prev_ff  <= 1'b0;
         pin_prev_ff <= 1'b0;
      end else begin
         rc_prev_ff  <= rc_s;
         por_prev_ff <= por_s;
         bo_prev_ff  <= bo_trip;
         pin_prev_ff <= pin_n_s;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in || por_evt) begin
         bo_cause_ff <= 1'b0;
      end else if (bo_evt) begin
         bo_cause_ff <= 1'b1;
      end
   end

   // ****************************************
   // Time-out sequence
   // ****************************************
   delay_counter #(.WIDTH(`POWERUP_WIDTH), .LENGTH(POWERUP_DELAY_TICKS)) u_powerup_timer (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (state_ff != st_powerup),
      .step_in    ((state_ff == st_powerup) && rc_tick),
      .done_out   (powerup_done)
   );

   delay_counter #(.WIDTH(`STARTUP_WIDTH), .LENGTH(`STARTUP_CYCLES)) u_oscillator_startup_timer (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .load_in    (state_ff != st_osc_startup && state_ff != st_wake_startup),
      .step_in    (state_ff == st_osc_startup || state_ff == st_wake_startup),
      .done_out   (osc_startup_done)
   );

   // Pin level is ignored here so the timers run while it is held low
   always_comb begin
      nxt_state = state_ff;
      if (por_s || bo_trip) begin
         nxt_state = st_hold;
      end else begin
         case (state_ff)
            st_hold: begin
               if (bo_cause_ff || powerup_on_por) begin
                  nxt_state = st_powerup;
               end else if (crystal) begin
                  nxt_state = st_osc_startup;
               end else begin
                  nxt_state = st_run;
               end
            end
            st_powerup: begin
               if (powerup_done) begin
                  nxt_state = crystal ? st_osc_startup : st_run;
               end
            end
            st_osc_startup, st_wake_startup: begin
               if (osc_startup_done) begin
                  nxt_state = st_run;
               end
            end
            st_run: begin
               if (wdt_rst_evt) begin
                  nxt_state = st_wdt_rst;
               end else if ((wdt_wake_evt || irq_wake_evt) && crystal) begin
                  nxt_state = st_wake_startup;
               end
            end
            st_wdt_rst: begin
               nxt_state = st_run;
            end
            default: begin
               nxt_state = st_hold;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         state_ff <= st_hold;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         reset_out     <= 1'b1;
         core_hold_out <= 1'b0;
      end else begin
         reset_out     <= (nxt_state != st_run && nxt_state != st_wake_startup) ||
                          !pin_n_s || por_s;
         core_hold_out <= (nxt_state == st_wake_startup);
      end
   end

   // ****************************************
   // Cause flags and register-load strobes
   // ****************************************
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || por_evt || bo_evt) begin
         timeout_flag_n_out   <= 1'b1;
         powerdown_flag_n_out <= 1'b1;
      end else if (pin_evt && sleeping_in) begin
         timeout_flag_n_out   <= 1'b1;
         powerdown_flag_n_out <= 1'b0;
      end else if (wdt_rst_evt) begin
         timeout_flag_n_out   <= 1'b0;
         powerdown_flag_n_out <= 1'b1;
      end else if (wdt_wake_evt) begin
         timeout_flag_n_out   <= 1'b0;
         powerdown_flag_n_out <= 1'b0;
      end else if (irq_wake_evt) begin
         timeout_flag_n_out   <= 1'b1;
         powerdown_flag_n_out <= 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         pc_load_out     <= 1'b0;
         pc_value_out    <= `PC_RESET_VECTOR;
         pc_advance_out  <= 1'b0;
         periph_init_out <= 1'b0;
         period_init_out <= 1'b0;
      end else begin
         pc_load_out     <= any_rst_evt || (irq_wake_evt && global_irq_enable_in);
         pc_value_out    <= (irq_wake_evt && global_irq_enable_in) ?
                            `PC_IRQ_VECTOR : `PC_RESET_VECTOR;
         pc_advance_out  <= wdt_wake_evt || (irq_wake_evt && !global_irq_enable_in);
         periph_init_out <= any_rst_evt;
         period_init_out <= any_rst_evt || wdt_wake_evt || irq_wake_evt;
      end
   end

   // ****************************************
   // Register port
   // ****************************************
   // A hardware clear lands after the write, so the event always wins
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         bo_flag_n_ff <= 1'b1;
         po_flag_n_ff <= 1'b0;
         osc_fast_ff  <= 1'b1;
      end else begin
         if (reg_wr_in && reg_addr_in == `ADDR_POWER_STATUS) begin
            bo_flag_n_ff <= reg_wdata_in[`PS_BROWNOUT_BIT];
            po_flag_n_ff <= reg_wdata_in[`PS_POWERON_BIT];
            osc_fast_ff  <= reg_wdata_in[`PS_OSC_FAST_BIT];
         end
         if (bo_evt) begin
            bo_flag_n_ff <= 1'b0;
         end
         if (por_evt) begin
            po_flag_n_ff <= 1'b0;
         end
         if (any_rst_evt) begin
            osc_fast_ff <= 1'b1;
         end
      end
   end

   // Configuration survives every reset except the logic reset itself
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         cfg_ff <= `CONFIG_RESET;
      end else if (reg_wr_in && reg_addr_in == `ADDR_CONFIG) begin
         cfg_ff <= reg_wdata_in;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         brownout_trip_voltage_out <= 2'h0;
      end else begin
         brownout_trip_voltage_out <= cfg_ff[`CFG_TRIP_LSB +: 2];
      end
   end

   always_comb begin
      ps_view = 8'h00;
      ps_view[`PS_BROWNOUT_BIT] = bo_flag_n_ff;
      ps_view[`PS_POWERON_BIT]  = po_flag_n_ff;
      ps_view[`PS_OSC_FAST_BIT] = osc_fast_ff;
      rs_view = 8'h00;
      rs_view[`RS_TIMEOUT_BIT]   = timeout_flag_n_out;
      rs_view[`RS_POWERDOWN_BIT] = powerdown_flag_n_out;
      rs_view[`RS_HOLD_BIT]      = core_hold_out;
      rs_view[`RS_RESET_BIT]     = reset_out;
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in || !reg_rd_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         case (reg_addr_in)
            `ADDR_POWER_STATUS: reg_rdata_out <= ps_view;
            `ADDR_RESET_STATUS: reg_rdata_out <= rs_view;
            `ADDR_CONFIG:       reg_rdata_out <= cfg_ff;
            default:            reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   logic [10:0] startup_cyc_ff;
   always_ff @(posedge clock_in) begin
      if (sys_rst_in || state_ff != st_osc_startup) begin
         startup_cyc_ff <= 11'h000;
      end else begin
         startup_cyc_ff <= startup_cyc_ff + 11'h001;
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);

   property p_startup_length;
      $fell(state_ff == st_osc_startup) |->
         (state_ff == st_hold) || (startup_cyc_ff == 11'h400);
   endproperty
   a_startup_length: assert property (p_startup_length) else $error("start-up count not 1024");

   property p_startup_crystal;
      (state_ff == st_osc_startup || state_ff == st_wake_startup) |-> is_crystal(mode);
   endproperty
   a_startup_crystal: assert property (p_startup_crystal) else $error("start-up in bad mode");

   property p_trip_select;
      (reg_wr_in && reg_addr_in == `ADDR_CONFIG) |->
         ##2 brownout_trip_voltage_out == $past(reg_wdata_in[`CFG_TRIP_LSB +: 2], 2);
   endproperty
   a_trip_select: assert property (p_trip_select) else $error("trip level not applied");

   property p_bo_disabled;
      !bo_en |-> !bo_evt && !bo_trip;
   endproperty
   a_bo_disabled: assert property (p_bo_disabled) else $error("brown-out while disabled");

   property p_bo_hold;
      (bo_trip && !por_s) |=> state_ff == st_hold && reset_out;
   endproperty
   a_bo_hold: assert property (p_bo_hold) else $error("brown-out did not hold reset");

   property p_powerup_restart;
      (state_ff == st_powerup && bo_trip) |=>
         state_ff == st_hold ##1 state_ff != st_osc_startup;
   endproperty
   a_powerup_restart: assert property (p_powerup_restart) else $error("dip did not restart delay");

   property p_startup_after_powerup;
      $rose(state_ff == st_osc_startup) |-> $past(state_ff) == st_powerup ||
                                   ($past(state_ff) == st_hold && !$past(powerup_on_por));
   endproperty
   a_startup_after_powerup: assert property (p_startup_after_powerup) else $error("start-up too early");

   property p_bo_flag;
      bo_evt |=> !bo_flag_n_ff;
   endproperty
   a_bo_flag: assert property (p_bo_flag) else $error("brown-out flag not cleared");

   property p_por_flag;
      $fell(po_flag_n_ff) |-> $past(por_evt) || $past(reg_wr_in);
   endproperty
   a_por_flag: assert property (p_por_flag) else $error("power-on flag cleared wrongly");

   property p_por_status;
      por_evt |=> timeout_flag_n_out && powerdown_flag_n_out && pc_load_out;
   endproperty
   a_por_status: assert property (p_por_status) else $error("power-on status wrong");

   property p_irq_vector;
      (irq_wake_evt && global_irq_enable_in) |=> pc_load_out && pc_value_out == `PC_IRQ_VECTOR;
   endproperty
   a_irq_vector: assert property (p_irq_vector) else $error("interrupt wake vector wrong");

   property p_wake_regs;
      wdt_wake_evt |=> period_init_out && !periph_init_out && pc_advance_out;
   endproperty
   a_wake_regs: assert property (p_wake_regs) else $error("wake touched registers");

   property p_hold_reset;
      (state_ff == st_powerup || state_ff == st_osc_startup || state_ff == st_hold) |-> reset_out;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("reset released while timing");

   c_por_to_run: cover property ($rose(state_ff == st_run) && timeout_flag_n_out);
   c_bo_in_powerup: cover property (state_ff == st_powerup && bo_trip);
   c_irq_vector: cover property (irq_wake_evt && global_irq_enable_in);
   c_pin_reset:  cover property (pin_evt && sleeping_in);
endmodule // reset_timeout_sequencer
`default_nettype wire

// ### test/reset_timeout_sequencer_tb.sv
// Self-checking bench for the reset and time-out sequencer
`timescale 1ns/1ns
`default_nettype none
module reset_timeout_sequencer_tb;
   import reset_seq_pkg::*;
   logic        clock_in, sys_rst_in, por, below, pin_n, rc, wdt, irq, sleeping, irq_en;
   logic        wr, rd, reset_out, hold, pc_load, pc_adv, p_init, r_init, to_n, pdown_n;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [12:0] pc_value;
   logic [1:0]  trip;
   int          err_total = 0;
   int          checked = 0;

   reset_timeout_sequencer #(.POWERUP_DELAY_TICKS(3)) DUT (.clock_in(clock_in),
      .sys_rst_in(sys_rst_in), .por_pulse_in(por), .brownout_below_in(below),
      .external_reset_pin_n_in(pin_n), .rc_timebase_in(rc), .wdt_timeout_in(wdt),
      .irq_wake_in(irq), .sleeping_in(sleeping), .global_irq_enable_in(irq_en),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .reset_out(reset_out), .core_hold_out(hold),
      .pc_load_out(pc_load), .pc_value_out(pc_value), .pc_advance_out(pc_adv),
      .periph_init_out(p_init), .period_init_out(r_init), .timeout_flag_n_out(to_n),
      .powerdown_flag_n_out(pdown_n), .brownout_trip_voltage_out(trip));

   // ***************
   // Clocks
   // ***************
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // RC timebase is free running and unrelated in phase to the main clock
   initial begin
      rc = 1'b0;
      #3;
      forever #37 rc = ~rc;
   end

   // ***************
   // Helpers
   // ***************
   task automatic chk(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_in);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge clock_in);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      rd <= 1'b1; addr <= a;
      @(posedge clock_in);
      rd <= 1'b0;
      #1 chk(13'(rdata), 13'(exp));
   endtask
   task automatic wait_rst(input logic lvl, input int max);
      int n;
      n = 0;
      while (reset_out !== lvl && n < max) begin
         cyc(1);
         n++;
      end
      chk(13'(reset_out), 13'(lvl));
   endtask
   // Waits for the PC load pulse, then checks vector and cause flags
   task automatic pulse_chk(input logic [12:0] pc, input logic t, input logic p,
                            input logic pi, input logic ri);
      int n;
      #1;
      n = 0;
      while (pc_load !== 1'b1 && n < 6) begin
         cyc(1);
         n++;
      end
      chk(13'(pc_load), 13'h0001);
      chk(pc_value, pc);
      chk(13'(p_init), 13'(pi));
      chk(13'(r_init), 13'(ri));
      cyc(2);
      chk(13'({to_n, pdown_n}), 13'({t, p}));
   endtask

   // ***************
   // Scenarios
   // ***************
   task automatic t_poweron();
      cyc(3);
      por <= 1'b0;
      cyc(1000);
      chk(13'(reset_out), 13'h0001);
      wait_rst(1'b0, 300);
      rd_reg(4'h0, 8'h09);
      chk(13'({to_n, pdown_n}), 13'h0003);
      $display("power-on test done");
   endtask
   task automatic t_brownout();
      wr_reg(4'h2, 8'h3A);
      rd_reg(4'h2, 8'h3A);
      rd_reg(4'hF, 8'h00);
      chk(13'(trip), 13'h0002);
      wr_reg(4'h0, 8'h0B);
      below <= 1'b1;
      cyc(4);
      below <= 1'b0;
      cyc(20);
      chk(13'(reset_out), 13'h0000);
      below <= 1'b1;
      wait_rst(1'b1, 30);
      rd_reg(4'h0, 8'h0A);
      cyc(30);
      below <= 1'b0;
      cyc(3);
      chk(13'(reset_out), 13'h0001);
      wait_rst(1'b0, 100);
      $display("brown-out test done");
   endtask
   task automatic t_events();
      @(posedge clock_in);
      wdt <= 1'b1;
      @(posedge clock_in);
      wdt <= 1'b0;
      pulse_chk(13'h0000, 1'b0, 1'b1, 1'b1, 1'b1);
      wait_rst(1'b0, 20);
      sleeping <= 1'b1; irq_en <= 1'b1; irq <= 1'b1;
      @(posedge clock_in);
      irq <= 1'b0;
      pulse_chk(13'h0004, 1'b1, 1'b0, 1'b0, 1'b1);
      pin_n <= 1'b0;
      wait_rst(1'b1, 10);
      cyc(5);
      pin_n <= 1'b1;
      wait_rst(1'b0, 10);
      chk(13'({to_n, pdown_n}), 13'h0002);
      $display("event test done");
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      sys_rst_in = 1'b1; por = 1'b1; below = 1'b0; pin_n = 1'b1; wdt = 1'b0;
      irq = 1'b0; sleeping = 1'b0; irq_en = 1'b0; wr = 1'b0; rd = 1'b0;
      addr = 4'h0; wdata = 8'h00;
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      t_poweron();
      t_brownout();
      t_events();
      tally_and_finish();
   end

   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
endmodule // reset_timeout_sequencer_tb
`default_nettype wire
